// ---- verilog/stb_bank.sv ----
`timescale 1ns/10ps
module stb_bank (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire stb_pkg::stb_req_t req,
  output logic [7:0] rdata,
  input wire stb_pkg::stb_ack_t ack,
  input wire stb_pkg::stb_pins_t pins,
  input wire logic timer_a_prescale_select,
  input wire logic timer_b_prescale_select,
  input wire logic ext_mem_active,
  input wire logic [7:0] ext_addr_low,
  input wire logic ext_data_drive,
  input wire logic [7:0] ext_data_out,
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out,
  output logic [7:0] port_zero_oe_n,
  output logic [7:0] stack_pointer,
  output logic [15:0] active_data_pointer,
  input wire logic active_data_pointer_load,
  input wire logic [15:0] active_data_pointer_value,
  output logic baud_double,
  output logic framing_check_enable,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic timer_a_overflow,
  output logic timer_b_overflow,
  output logic ext_a_event_flag,
  output logic ext_b_event_flag
);
  import stb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic bit_capable(input logic [7:0] a);
    bit_capable = (a[2:0] == 3'h0);
  endfunction

  function automatic logic [7:0] merge_bit(input logic [7:0] cur, input stb_req_t r);
    logic [7:0] v;
    v = cur;
    v[r.bit_sel] = r.bit_val;
    merge_bit = r.bit_op ? v : r.wdata;
  endfunction

  // Register file
  logic [7:0] port0_reg;
  logic [7:0] sp_reg;
  logic [7:0] dpl_reg;
  logic [7:0] dph_reg;
  logic [7:0] alt_pointer_low_reg;
  logic [7:0] alt_pointer_high_reg;
  logic dps_reg;
  logic [7:0] pwr_reg;
  logic [7:0] tctl_reg;
  logic [7:0] tmode_reg;
  // Timer counts, their next values and the pin history
  logic [7:0] tal_reg;
  logic [7:0] tah_reg;
  logic [7:0] tbl_reg;
  logic [7:0] tbh_reg;
  logic [7:0] tctl_next;
  logic [7:0] tal_next;
  logic [7:0] tah_next;
  logic [7:0] tbl_next;
  logic [7:0] tbh_next;
  logic [4:0] pre_a_next;
  logic [4:0] pre_b_next;
  logic [3:0] pins_s1;
  logic [3:0] pins_s2;
  logic [3:0] pins_s3;
  logic [4:0] pre_a_reg;
  logic [4:0] pre_b_reg;
  logic [3:0] div_a_reg;
  logic [3:0] div_b_reg;
  // Access qualification
  logic acc_ok;
  logic wr_en;
  logic bit_ok;
  logic [7:0] wval;

  // Indirect access never reaches this page; bit ops only at x0h/x8h
  assign acc_ok = req.addr[7] && !req.indirect;
  assign bit_ok = !req.bit_op || bit_capable(req.addr);
  assign wr_en = req.wr && acc_ok && bit_ok;

  always_comb begin
    unique case (req.addr)
      ADDR_PORT0: wval = merge_bit(port0_reg, req);
      ADDR_TCTL: wval = merge_bit(tctl_reg, req);
      default: wval = req.wdata;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from outside; two stages before use, third for edge detect
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pins_s1 <= 4'hF;
      pins_s2 <= 4'hF;
      pins_s3 <= 4'hF;
    end else begin
      pins_s1 <= {pins.count_b_pin, pins.count_a_pin, pins.ext_b_pin, pins.ext_a_pin};
      pins_s2 <= pins_s1;
      pins_s3 <= pins_s2;
    end
  end

  logic ia;
  logic ib;
  logic ia_fall;
  logic ib_fall;
  logic ta_fall;
  logic tb_fall;
  assign ia = pins_s2[0];
  assign ib = pins_s2[1];
  assign ia_fall = pins_s3[0] && !pins_s2[0];
  assign ib_fall = pins_s3[1] && !pins_s2[1];
  assign ta_fall = pins_s3[2] && !pins_s2[2];
  assign tb_fall = pins_s3[3] && !pins_s2[3];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      port0_reg <= RST_PORT0;
      sp_reg <= RST_SP;
      dpl_reg <= RST_ZERO;
      dph_reg <= RST_ZERO;
      alt_pointer_low_reg <= RST_ZERO;
      alt_pointer_high_reg <= RST_ZERO;
      dps_reg <= 1'b0;
      pwr_reg <= RST_ZERO;
      tmode_reg <= RST_ZERO;
    end else begin
      if (wr_en && req.addr == ADDR_PORT0) port0_reg <= wval;
      if (wr_en && req.addr == ADDR_SP) sp_reg <= req.wdata;
      if (wr_en && req.addr == ADDR_DPSEL) dps_reg <= req.wdata[0];
      if (wr_en && req.addr == ADDR_PWR) pwr_reg <= req.wdata & ~PWR_UNUSED_MASK;
      if (wr_en && req.addr == ADDR_TMODE) tmode_reg <= req.wdata;
      // Core pointer update goes to the selected pair only
      if (active_data_pointer_load && !dps_reg) begin
        {dph_reg, dpl_reg} <= active_data_pointer_value;
      end else begin
        if (wr_en && req.addr == ADDR_DPL) dpl_reg <= req.wdata;
        if (wr_en && req.addr == ADDR_DPH) dph_reg <= req.wdata;
      end
      if (active_data_pointer_load && dps_reg) begin
        {alt_pointer_high_reg, alt_pointer_low_reg} <= active_data_pointer_value;
      end else begin
        if (wr_en && req.addr == ADDR_DPL_ALT) alt_pointer_low_reg <= req.wdata;
        if (wr_en && req.addr == ADDR_DPH_ALT) alt_pointer_high_reg <= req.wdata;
      end
    end
  end

  assign active_data_pointer = dps_reg ? {alt_pointer_high_reg, alt_pointer_low_reg} : {dph_reg, dpl_reg};
  assign stack_pointer = sp_reg;
  assign baud_double = pwr_reg[PWR_BAUD_DOUBLE];
  assign framing_check_enable = pwr_reg[PWR_FRAME_EN];
  // Power-down clears both the CPU and peripheral clock enables; idle keeps peripherals alive
  assign cpu_clk_en = !pwr_reg[PWR_POWER_DOWN] && !pwr_reg[PWR_SLEEP];
  assign periph_clk_en = !pwr_reg[PWR_POWER_DOWN];

  ////////////////////////////////////////////////////////////////////////////
  // Port zero: external cycles drive strongly, otherwise open-drain
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      port_zero_out <= RST_ZERO;
      port_zero_oe_n <= 8'hFF;
    end else if (ext_mem_active) begin
      port_zero_out <= ext_data_drive ? ext_data_out : ext_addr_low;
      port_zero_oe_n <= ext_data_drive ? 8'h00 : 8'h00;
    end else begin
      port_zero_out <= RST_ZERO;
      port_zero_oe_n <= port0_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescale ticks
  logic tick_a;
  logic tick_b;
  assign tick_a = div_a_reg == (timer_a_prescale_select ? PRESCALE_FAST : PRESCALE_SLOW);
  assign tick_b = div_b_reg == (timer_b_prescale_select ? PRESCALE_FAST : PRESCALE_SLOW);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_a_reg <= 4'h0;
      div_b_reg <= 4'h0;
    end else if (periph_clk_en) begin
      div_a_reg <= tick_a ? 4'h0 : div_a_reg + 4'h1;
      div_b_reg <= tick_b ? 4'h0 : div_b_reg + 4'h1;
    end
  end

  stb_mode_t mode_a;
  stb_mode_t mode_b;
  logic run_a;
  logic run_b;
  logic inc_a;
  logic inc_b;
  logic inc_ah;
  assign mode_a = stb_mode_t'(tmode_reg[1:0]);
  assign mode_b = stb_mode_t'(tmode_reg[5:4]);
  assign run_a = tctl_reg[TC_A_RUN] && (!tmode_reg[3] || ia);
  assign run_b = tctl_reg[TC_B_RUN] && (!tmode_reg[7] || ib);
  assign inc_a = periph_clk_en && run_a && (tmode_reg[2] ? ta_fall : tick_a);
  assign inc_b = periph_clk_en && run_b && (tmode_reg[6] ? tb_fall : tick_b)
                 && mode_b != STB_MODE_SPLIT && mode_a != STB_MODE_SPLIT;
  // Split mode high byte of A: internal ticks, run by B's run bit
  assign inc_ah = periph_clk_en && tctl_reg[TC_B_RUN] && tick_a;

  logic ovf_a;
  logic ovf_b;
  logic ovf_ah;

  always_comb begin
    tal_next = tal_reg;
    tah_next = tah_reg;
    ovf_a = 1'b0;
    ovf_ah = 1'b0;
    pre_a_next = pre_a_reg;
    if (inc_a) begin
      unique case (mode_a)
        STB_MODE_PRE: begin
          pre_a_next = pre_a_reg + 5'h1;
          if (pre_a_reg == MODE0_PRE_MAX) begin
            tah_next = tah_reg + 8'h01;
            ovf_a = tah_reg == 8'hFF;
          end
        end
        STB_MODE_WIDE: begin
          {tah_next, tal_next} = {tah_reg, tal_reg} + 16'h0001;
          ovf_a = {tah_reg, tal_reg} == 16'hFFFF;
        end
        STB_MODE_RELOAD: begin
          ovf_a = tal_reg == 8'hFF;
          tal_next = ovf_a ? tah_reg : tal_reg + 8'h01;
        end
        STB_MODE_SPLIT: begin
          tal_next = tal_reg + 8'h01;
          ovf_a = tal_reg == 8'hFF;
        end
      endcase
    end
    if (inc_ah && mode_a == STB_MODE_SPLIT) begin
      tah_next = tah_reg + 8'h01;
      ovf_ah = tah_reg == 8'hFF;
    end
  end

  always_comb begin
    tbl_next = tbl_reg;
    tbh_next = tbh_reg;
    ovf_b = 1'b0;
    pre_b_next = pre_b_reg;
    if (inc_b) begin
      unique case (mode_b)
        STB_MODE_PRE: begin
          pre_b_next = pre_b_reg + 5'h1;
          if (pre_b_reg == MODE0_PRE_MAX) begin
            tbh_next = tbh_reg + 8'h01;
            ovf_b = tbh_reg == 8'hFF;
          end
        end
        STB_MODE_WIDE: begin
          {tbh_next, tbl_next} = {tbh_reg, tbl_reg} + 16'h0001;
          ovf_b = {tbh_reg, tbl_reg} == 16'hFFFF;
        end
        STB_MODE_RELOAD: begin
          ovf_b = tbl_reg == 8'hFF;
          tbl_next = ovf_b ? tbh_reg : tbl_reg + 8'h01;
        end
        STB_MODE_SPLIT: begin
          tbl_next = tbl_reg;
        end
      endcase
    end
  end

  // Software writes to counts win over counting in that cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tal_reg <= RST_ZERO;
      tah_reg <= RST_ZERO;
      tbl_reg <= RST_ZERO;
      tbh_reg <= RST_ZERO;
      pre_a_reg <= 5'h00;
      pre_b_reg <= 5'h00;
    end else begin
      pre_a_reg <= pre_a_next;
      pre_b_reg <= pre_b_next;
      tal_reg <= (wr_en && req.addr == ADDR_TA_LO) ? req.wdata : tal_next;
      tah_reg <= (wr_en && req.addr == ADDR_TA_HI) ? req.wdata : tah_next;
      tbl_reg <= (wr_en && req.addr == ADDR_TB_LO) ? req.wdata : tbl_next;
      tbh_reg <= (wr_en && req.addr == ADDR_TB_HI) ? req.wdata : tbh_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer control: hardware set beats software or vector clear
  always_comb begin
    tctl_next = tctl_reg;
    if (wr_en && req.addr == ADDR_TCTL) tctl_next = wval;
    if (ack.a_vector) tctl_next[TC_A_OVF] = 1'b0;
    if (ack.b_vector) tctl_next[TC_B_OVF] = 1'b0;
    if (ovf_a) tctl_next[TC_A_OVF] = 1'b1;
    if (ovf_b || ovf_ah) tctl_next[TC_B_OVF] = 1'b1;
    if (tctl_reg[TC_A_TYPE]) begin
      if (ack.ext_a_vector) tctl_next[TC_A_EVT] = 1'b0;
      if (ia_fall) tctl_next[TC_A_EVT] = 1'b1;
    end else begin
      tctl_next[TC_A_EVT] = !ia;
    end
    if (tctl_reg[TC_B_TYPE]) begin
      if (ack.ext_b_vector) tctl_next[TC_B_EVT] = 1'b0;
      if (ib_fall) tctl_next[TC_B_EVT] = 1'b1;
    end else begin
      tctl_next[TC_B_EVT] = !ib;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) tctl_reg <= RST_ZERO;
    else tctl_reg <= tctl_next;
  end

  assign timer_a_overflow = tctl_reg[TC_A_OVF];
  assign timer_b_overflow = tctl_reg[TC_B_OVF];
  assign ext_a_event_flag = tctl_reg[TC_A_EVT];
  assign ext_b_event_flag = tctl_reg[TC_B_EVT];

  ////////////////////////////////////////////////////////////////////////////
  // Read data registered; one cycle latency
  logic [7:0] rd_mux;
  always_comb begin
    unique case (req.addr)
      ADDR_PORT0: rd_mux = port0_reg;
      ADDR_SP: rd_mux = sp_reg;
      ADDR_DPL: rd_mux = dpl_reg;
      ADDR_DPH: rd_mux = dph_reg;
      ADDR_DPL_ALT: rd_mux = alt_pointer_low_reg;
      ADDR_DPH_ALT: rd_mux = alt_pointer_high_reg;
      ADDR_DPSEL: rd_mux = {7'h00, dps_reg};
      ADDR_PWR: rd_mux = pwr_reg | PWR_UNUSED_MASK;
      ADDR_TCTL: rd_mux = tctl_reg;
      ADDR_TMODE: rd_mux = tmode_reg;
      ADDR_TA_LO: rd_mux = tal_reg;
      ADDR_TB_LO: rd_mux = tbl_reg;
      ADDR_TA_HI: rd_mux = tah_reg;
      ADDR_TB_HI: rd_mux = tbh_reg;
      default: rd_mux = UNIMPL_READ;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) rdata <= UNIMPL_READ;
    else if (req.rd && acc_ok) rdata <= rd_mux;
    else if (req.rd) rdata <= UNIMPL_READ;
  end
endmodule // stb_bank

// ---- verilog/stb_pkg.sv ----
package stb_pkg;
  localparam logic [7:0] SR_BASE = 8'h80;
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_SP = 8'h81;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  localparam logic [7:0] ADDR_DPL_ALT = 8'h84;
  localparam logic [7:0] ADDR_DPH_ALT = 8'h85;
  localparam logic [7:0] ADDR_DPSEL = 8'h86;
  localparam logic [7:0] ADDR_PWR = 8'h87;
  localparam logic [7:0] ADDR_TCTL = 8'h88;
  localparam logic [7:0] ADDR_TMODE = 8'h89;
  localparam logic [7:0] ADDR_TA_LO = 8'h8A;
  localparam logic [7:0] ADDR_TB_LO = 8'h8B;
  localparam logic [7:0] ADDR_TA_HI = 8'h8C;
  localparam logic [7:0] ADDR_TB_HI = 8'h8D;
  localparam logic [7:0] RST_PORT0 = 8'hFF;
  localparam logic [7:0] RST_SP = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] UNIMPL_READ = 8'hFF;
  localparam logic [7:0] PWR_UNUSED_MASK = 8'h30;
  localparam logic [3:0] PRESCALE_FAST = 4'h3;
  localparam logic [3:0] PRESCALE_SLOW = 4'hB;
  localparam logic [4:0] MODE0_PRE_MAX = 5'h1F;
  // Power control bit positions
  localparam int PWR_BAUD_DOUBLE = 7;
  localparam int PWR_FRAME_EN = 6;
  localparam int PWR_POWER_DOWN = 1;
  localparam int PWR_SLEEP = 0;
  // Timer control bit positions
  localparam int TC_B_OVF = 7;
  localparam int TC_B_RUN = 6;
  localparam int TC_A_OVF = 5;
  localparam int TC_A_RUN = 4;
  localparam int TC_B_EVT = 3;
  localparam int TC_B_TYPE = 2;
  localparam int TC_A_EVT = 1;
  localparam int TC_A_TYPE = 0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic indirect;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic bit_val;
    logic [7:0] wdata;
  } stb_req_t;

  typedef struct packed {
    logic a_vector;
    logic b_vector;
    logic ext_a_vector;
    logic ext_b_vector;
  } stb_ack_t;

  typedef struct packed {
    logic ext_a_pin;
    logic ext_b_pin;
    logic count_a_pin;
    logic count_b_pin;
  } stb_pins_t;

  typedef enum logic [1:0] {
    STB_MODE_PRE, STB_MODE_WIDE, STB_MODE_RELOAD, STB_MODE_SPLIT
  } stb_mode_t;
endpackage

// ---- verification/stb_bank_chk.sv ----
`timescale 1ns/10ps
module stb_bank_chk
  import stb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire stb_pkg::stb_req_t req,
  input wire logic [7:0] rdata,
  input wire stb_pkg::stb_ack_t ack,
  input wire logic [7:0] stack_pointer,
  input wire logic baud_double,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic timer_a_overflow
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wr(a);
    req.wr && !req.indirect && !req.bit_op && req.addr == a;
  endsequence
  sequence s_rd_direct;
    req.rd && !req.indirect;
  endsequence
  property p_bad_rd;
    req.rd && (req.indirect || !req.addr[7]) |=> rdata == UNIMPL_READ;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("refused read not all ones");
  property p_gap_rd;
    s_rd_direct ##0 req.addr >= 8'h8E |=> rdata == UNIMPL_READ;
  endproperty
  a_gap_rd: assert property (p_gap_rd) else $error("unmapped read not all ones");
  property p_sel_rd;
    s_rd_direct ##0 req.addr == ADDR_DPSEL |=> rdata[7:1] == 7'h00;
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("select upper bits not zero");
  property p_sp_wr;
    s_wr(ADDR_SP) |=> stack_pointer == $past(req.wdata);
  endproperty
  a_sp_wr: assert property (p_sp_wr) else $error("stack pointer missed write");
  property p_ind_wr;
    req.wr && req.indirect |=> $stable(stack_pointer);
  endproperty
  a_ind_wr: assert property (p_ind_wr) else $error("indirect write took effect");
  property p_bit_sp;
    req.wr && req.bit_op && !req.indirect && req.addr == ADDR_SP |=> $stable(stack_pointer);
  endproperty
  a_bit_sp: assert property (p_bit_sp) else $error("bit write at odd address");
  property p_pd;
    s_wr(ADDR_PWR) ##0 req.wdata[PWR_POWER_DOWN] |=> !cpu_clk_en && !periph_clk_en;
  endproperty
  a_pd: assert property (p_pd) else $error("power down left a clock on");
  property p_idle;
    s_wr(ADDR_PWR) ##0 (req.wdata[1:0] == 2'h1 && periph_clk_en) |=> !cpu_clk_en && periph_clk_en;
  endproperty
  a_idle: assert property (p_idle) else $error("idle clock gating wrong");
  property p_baud;
    s_wr(ADDR_PWR) ##0 periph_clk_en |=> baud_double == $past(req.wdata[PWR_BAUD_DOUBLE]);
  endproperty
  a_baud: assert property (p_baud) else $error("baud double not written");
  property p_vec;
    ack.a_vector && !req.wr |=> !timer_a_overflow;
  endproperty
  a_vec: assert property (p_vec) else $error("overflow flag kept after vector");
endmodule // stb_bank_chk

bind stb_bank stb_bank_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata),
  .ack(ack), .stack_pointer(stack_pointer), .baud_double(baud_double),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .timer_a_overflow(timer_a_overflow));

// ---- verification/stb_core_model.sv ----
`timescale 1ns/10ps
module stb_core_model
  import stb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  output stb_pkg::stb_req_t req,
  output stb_pkg::stb_ack_t ack
);
  initial begin
    req = '0;
    ack = '0;
  end
  // One register access; idle address, bit and data fields show inverted values so stale data never looks valid
  task automatic acc(input logic w, input logic ind, input logic bo, input logic [7:0] a,
      input logic [2:0] bs, input logic bv, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    req <= '{wr: w, rd: !w, bit_op: bo, indirect: ind, addr: a, bit_sel: bs, bit_val: bv, wdata: d};
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b0, bit_op: 1'b0, indirect: 1'b0, addr: ~a, bit_sel: ~bs,
      bit_val: ~bv, wdata: ~d};
    #1 q = rdata;
  endtask
  task automatic vec(input stb_ack_t v);
    @(posedge sys_clk);
    ack <= v;
    @(posedge sys_clk);
    ack <= '0;
    #1;
  endtask
endmodule // stb_core_model

// ---- verification/tb_sfr_timer_pointer_power_bank.sv ----
`timescale 1ns/10ps
module tb_sfr_timer_pointer_power_bank;
  import stb_pkg::*;
  logic sys_clk, nrst, ta_sel, tb_sel, mem_act, baud, frame, cpu_en, per_en;
  logic ovf_a, ovf_b, ev_a, ev_b, dl, dd;
  logic [7:0] q, addr_lo, p, rdata, p0_out, p0_oe_n, sp, dout, np;
  logic [7:0] v [5];
  logic [15:0] adp, dv;
  stb_req_t req;
  stb_ack_t ack;
  stb_pins_t pins;
  int fail_count, n_checks, n;
  stb_bank dut (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata), .ack(ack),
    .pins(pins), .timer_a_prescale_select(ta_sel), .timer_b_prescale_select(tb_sel),
    .ext_mem_active(mem_act), .ext_addr_low(addr_lo), .ext_data_drive(dd),
    .ext_data_out(dout), .port_zero_in(8'hFF), .port_zero_out(p0_out),
    .port_zero_oe_n(p0_oe_n), .stack_pointer(sp), .active_data_pointer(adp),
    .active_data_pointer_load(dl), .active_data_pointer_value(dv), .baud_double(baud),
    .framing_check_enable(frame), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
    .timer_a_overflow(ovf_a), .timer_b_overflow(ovf_b), .ext_a_event_flag(ev_a),
    .ext_b_event_flag(ev_b));
  stb_core_model core (.sys_clk(sys_clk), .rdata(rdata), .req(req), .ack(ack));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bounded(input int k, input int lim);
    if (k >= lim) begin
      chk(16'(k), 16'(lim - 1));
      summarize();
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic rst();
    @(posedge sys_clk);
    nrst <= 1'b0;
    tick(4);
    nrst <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core.acc(1'b1, 1'b0, 1'b0, a, 3'h0, 1'b0, d, q);
  endtask
  task automatic bop(input logic [7:0] a, input int b, input logic bv);
    core.acc(1'b1, 1'b0, 1'b1, a, 3'(b), bv, 8'h00, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    core.acc(1'b0, 1'b0, 1'b0, a, 3'h0, 1'b0, 8'h00, q);
    chk(16'(q), 16'(e));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9a04));
    nrst = 1'b0;
    ta_sel = 1'b1;
    tb_sel = 1'($urandom);
    mem_act = 1'b0;
    addr_lo = 8'h00;
    dl = 1'b0;
    dd = 1'b0;
    dout = 8'h00;
    dv = 16'h0000;
    pins = '{ext_a_pin: 1'b1, ext_b_pin: 1'b1, count_a_pin: 1'b1, count_b_pin: 1'b1};
    fail_count = 0;
    n_checks = 0;
    rst();
    rdc(ADDR_PORT0, RST_PORT0);
    rdc(ADDR_SP, RST_SP);
    rdc(ADDR_PWR, PWR_UNUSED_MASK);
    for (int i = 0; i < 5; i++) begin
      v[i] = 8'($urandom);
      wr(8'(ADDR_SP + i), v[i]);
    end
    for (int i = 0; i < 5; i++) rdc(8'(ADDR_SP + i), v[i]);
    chk(16'(sp), 16'(v[0]));
    chk(adp, {v[2], v[1]});
    wr(ADDR_DPSEL, 8'hFF);
    rdc(ADDR_DPSEL, 8'h01);
    chk(adp, {v[4], v[3]});
    wr(ADDR_DPSEL, 8'h00);
    chk(adp, {v[2], v[1]});
    dv <= 16'($urandom);
    dl <= 1'b1;
    tick(1);
    dl <= 1'b0;
    chk(adp, dv);
    rdc(ADDR_DPL_ALT, v[3]);
    core.acc(1'b1, 1'b1, 1'b0, ADDR_SP, 3'h0, 1'b0, ~v[0], q);
    rdc(ADDR_SP, v[0]);
    core.acc(1'b0, 1'b1, 1'b0, ADDR_SP, 3'h0, 1'b0, 8'h00, q);
    chk(16'(q), 16'(UNIMPL_READ));
    rdc(8'h01, UNIMPL_READ);
    rdc(8'h8E, UNIMPL_READ);
    bop(ADDR_SP, 0, ~v[0][0]);
    rdc(ADDR_SP, v[0]);
    p = 8'($urandom);
    wr(ADDR_PORT0, p);
    tick(2);
    chk(16'(p0_oe_n), 16'(p));
    addr_lo <= 8'($urandom);
    mem_act <= 1'b1;
    tick(3);
    chk({p0_out, p0_oe_n}, {addr_lo, 8'h00});
    dout <= 8'($urandom);
    dd <= 1'b1;
    tick(2);
    chk({p0_out, p0_oe_n}, {dout, 8'h00});
    dd <= 1'b0;
    mem_act <= 1'b0;
    wr(ADDR_TMODE, 8'h02);
    wr(ADDR_TA_HI, 8'hF0);
    wr(ADDR_TA_LO, 8'hFE);
    bop(ADDR_TCTL, TC_A_RUN, 1'b1);
    for (n = 0; n < 40 && ovf_a !== 1'b1; n++) tick(1);
    bounded(n, 40);
    chk(16'(n >= 3 && n <= 10), 16'h0001);
    bop(ADDR_TCTL, TC_A_RUN, 1'b0);
    rdc(ADDR_TA_LO, 8'hF0);
    chk(16'(q & 8'hFE), 16'h00F0);
    core.vec('{a_vector: 1'b1, b_vector: 1'b0, ext_a_vector: 1'b0, ext_b_vector: 1'b0});
    chk(16'(ovf_a), 16'h0000);
    bop(ADDR_TCTL, TC_A_OVF, 1'b1);
    chk(16'(ovf_a), 16'h0001);
    bop(ADDR_TCTL, TC_A_TYPE, 1'b1);
    pins.ext_a_pin <= 1'b0;
    for (n = 0; n < 10 && ev_a !== 1'b1; n++) tick(1);
    bounded(n, 10);
    core.vec('{a_vector: 1'b0, b_vector: 1'b0, ext_a_vector: 1'b1, ext_b_vector: 1'b0});
    chk(16'(ev_a), 16'h0000);
    pins.ext_a_pin <= 1'b1;
    bop(ADDR_TCTL, TC_A_TYPE, 1'b0);
    tick(4);
    chk(16'(ev_a), 16'h0000);
    pins.ext_a_pin <= 1'b0;
    tick(4);
    chk(16'(ev_a), 16'h0001);
    // Timer A mode 0: 32 prescale ticks of four clocks before the high byte wraps
    bop(ADDR_TCTL, TC_A_OVF, 1'b0);
    wr(ADDR_TMODE, 8'h50);
    wr(ADDR_TA_HI, 8'hFF);
    bop(ADDR_TCTL, TC_A_RUN, 1'b1);
    for (n = 0; n < 200 && ovf_a !== 1'b1; n++) tick(1);
    bounded(n, 200);
    chk(16'(n >= 125 && n <= 128), 16'h0001);
    bop(ADDR_TCTL, TC_A_RUN, 1'b0);
    // Timer B mode 1 counting falling edges of its count pin
    np = 8'(2 + $urandom % 4);
    wr(ADDR_TB_HI, 8'hFF);
    wr(ADDR_TB_LO, 8'h00 - np);
    bop(ADDR_TCTL, TC_B_RUN, 1'b1);
    repeat (np) begin
      chk(16'(ovf_b), 16'h0000);
      pins.count_b_pin <= 1'b0;
      tick(1 + $urandom % 3);
      pins.count_b_pin <= 1'b1;
      tick(4);
    end
    chk(16'(ovf_b), 16'h0001);
    rdc(ADDR_TB_HI, 8'h00);
    // Gate: pin low blocks counting, pin high lets it through
    wr(ADDR_TMODE, 8'hD0);
    pins.ext_b_pin <= 1'b0;
    for (int g = 0; g < 2; g++) begin
      tick(4);
      chk(16'(ev_b), 16'(1 - g));
      pins.count_b_pin <= 1'b0;
      tick(2);
      pins.count_b_pin <= 1'b1;
      tick(4);
      rdc(ADDR_TB_LO, 8'(g));
      pins.ext_b_pin <= 1'b1;
    end
    // Split mode: A high byte runs on B's run bit and raises B's flag
    bop(ADDR_TCTL, TC_B_OVF, 1'b0);
    wr(ADDR_TMODE, 8'h03);
    wr(ADDR_TA_HI, 8'hFF);
    for (n = 0; n < 20 && ovf_b !== 1'b1; n++) tick(1);
    bounded(n, 20);
    rdc(ADDR_TA_HI, 8'h00);
    rdc(ADDR_TA_LO, 8'hF0);
    wr(ADDR_PWR, 8'hCC);
    chk({14'h0000, baud, frame}, 16'h0003);
    rdc(ADDR_PWR, 8'hFC);
    wr(ADDR_PWR, 8'h01);
    chk({14'h0000, cpu_en, per_en}, 16'h0001);
    rst();
    wr(ADDR_PWR, 8'h02);
    chk({14'h0000, cpu_en, per_en}, 16'h0000);
    summarize();
  end
endmodule // tb_sfr_timer_pointer_power_bank
